// ===== core/rtcc_pkg.sv
package rtcc_pkg;
  // configuration port byte addresses
  localparam logic [7:0] ADDR_COUNT_BASE = 8'h40; // counter bytes, lsb first
  localparam logic [7:0] ADDR_MATCH_BASE = 8'h48; // match bytes, lsb first
  localparam logic [7:0] ADDR_CTRL_STAT  = 8'h58; // control write / status read
  localparam int         NUM_BYTES       = 5;     // 40 bits as bytes
  localparam int         CNT_W           = 40;    // counter and match width
  // control field positions
  localparam int BIT_SOFT_RST  = 7;
  localparam int BIT_CNT_EN    = 6;
  localparam int BIT_MATCH_EN  = 5;
  localparam int BIT_XT_HI     = 4;
  localparam int BIT_XT_LO     = 3;
  localparam int BIT_CLR_MATCH = 2;
  localparam int BIT_CNT_RUN   = 1;
  localparam int BIT_OSC_SEL   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00; // control value after reset
  // status field positions
  localparam int ST_IN_RESET = 7;
  localparam int ST_COUNTING = 6;
  localparam int ST_MATCH    = 5;
  localparam int ST_PRE_CLK  = 2;
  localparam int ST_NONZERO  = 1;
  // pre-scaler: divide by 128, first step after 64 edges
  localparam int         PRE_W    = 7;
  localparam logic [6:0] PRE_LAST = 7'h3f; // count before the 64th edge
  // reset release on the config clock rising edge with this index, counted from zero
  localparam logic [1:0] REL_LAST = 2'h1;  // index of the second edge
endpackage : rtcc_pkg

// ===== core/rtcc_prescale.sv
`timescale 1ns/1ps
`default_nettype none
// divide-by-128 pre-scaler on counter clock edges
module rtcc_prescale (
  input  wire logic clk_sys, // system clock
  input  wire logic reset,   // sync reset, high
  input  wire logic clear,   // hold pre-scaler at zero
  input  wire logic step,    // one counter clock rising edge
  output logic      tick,    // pre-scaled clock rising edge
  output logic      level    // pre-scaled clock level
);
  import rtcc_pkg::*;

  logic [PRE_W-1:0] pre_ff;  // pre-scaler count
  logic [PRE_W-1:0] nxt_pre; // next count

  // clear dominates, else count edges
  assign nxt_pre = clear ? '0 : (step ? PRE_W'(pre_ff + 7'h01) : pre_ff);
  // 64th edge and then every 128 edges
  assign tick    = step & ~clear & (pre_ff == PRE_LAST);
  assign level   = pre_ff[PRE_W-1];

  // count register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end
endmodule : rtcc_prescale
`default_nettype wire

// ===== core/rtcc_core.sv
// Functional notes
// - supply down or soft reset clears counter block
// - reset releases on second config clock edge
// - count enable works only outside reset
// - first step at 64th edge, then every 128
// - enable low clears pre-scaler, keeps counter
// - match output high on equality when enabled
// - crystal mode output follows bits 4:3
// - clear-on-match clears at next pre-scaled edge
// - without clear-on-match counting continues past match
// - counter clear bit zero forces counter zero
// - bit 0 drives oscillator ownership select
// - control/status register at address 0x58
// - status reads show block state, not control
// - counter bytes at 0x40..0x44, lsb first
// - match bytes at 0x48..0x4c, lsb first
`timescale 1ns/1ps
`default_nettype none
module rtcc_core (
  input  wire logic       clk_sys,                  // system clock
  input  wire logic       reset,                    // sync reset, high
  input  wire logic       config_port_clock,        // times reset release
  input  wire logic       counter_clock,            // crystal derived clock
  input  wire logic       io_supply_up,             // io supply good
  input  wire logic [7:0] cfg_addr,                 // byte address
  input  wire logic [7:0] cfg_wdata,                // write byte
  input  wire logic       cfg_wr,                   // write strobe
  input  wire logic       cfg_rd,                   // read strobe
  output logic      [7:0] cfg_rdata,                // read byte
  output logic            cfg_rvalid,               // read byte valid
  output logic            match_output,             // match event out
  output logic      [1:0] crystal_mode_output,      // oscillator mode pins
  output logic            oscillator_select_output  // oscillator ownership
);
  import rtcc_pkg::*;

  // one-hot byte select of a five byte group
  function automatic logic [NUM_BYTES-1:0] byte_sel(input logic [7:0] addr, input logic [7:0] base);
    logic [NUM_BYTES-1:0] sel;
    sel = '0;
    for (int i = 0; i < NUM_BYTES; i++) begin
      sel[i] = (addr == 8'(base + 8'(i)));
    end
    return sel;
  endfunction : byte_sel

  logic [7:0]       ctrl_ff;        // control register
  logic [7:0]       nxt_ctrl;       // next control
  logic             blk_rst_ff;     // block held in reset
  logic             nxt_blk_rst;    // next block reset
  logic [1:0]       rel_ff;         // release edge count
  logic [1:0]       nxt_rel;        // next release count
  logic             cfg_clk_prv_ff; // config clock last sample
  logic             cnt_clk_prv_ff; // counter clock last sample
  logic [CNT_W-1:0] count_ff;       // 40-bit counter
  logic [CNT_W-1:0] nxt_count;      // next counter
  logic [CNT_W-1:0] match_ff;       // 40-bit match value
  logic [CNT_W-1:0] nxt_match;      // next match value
  logic [CNT_W-1:0] cnt_wr_val;     // counter with written byte
  logic [CNT_W-1:0] mat_wr_val;     // match with written byte
  logic             match_out_ff;   // match output flop
  logic             nxt_match_out;  // next match output
  logic [7:0]       rdata_ff;       // read data flop
  logic [7:0]       nxt_rdata;      // next read data
  logic             rvalid_ff;      // read valid flop

  wire                 hold_src  = ~io_supply_up | ctrl_ff[BIT_SOFT_RST];     // reset causes
  wire                 hold      = hold_src | blk_rst_ff;                     // block in reset
  wire                 cfg_rise  = config_port_clock & ~cfg_clk_prv_ff;       // config clock edge
  wire                 cnt_rise  = counter_clock & ~cnt_clk_prv_ff;           // counter clock edge
  wire                 run       = ctrl_ff[BIT_CNT_EN] & ~hold;
  wire                 cnt_clr   = ~ctrl_ff[BIT_CNT_RUN];                     // counter forced zero
  wire [NUM_BYTES-1:0] cnt_sel   = byte_sel(cfg_addr, ADDR_COUNT_BASE);       // counter byte hit
  wire [NUM_BYTES-1:0] mat_sel   = byte_sel(cfg_addr, ADDR_MATCH_BASE);       // match byte hit
  wire                 cnt_wr    = cfg_wr & (|cnt_sel);                       // counter byte write
  wire                 mat_wr    = cfg_wr & (|mat_sel);                       // match byte write
  wire                 ctrl_hit  = (cfg_addr == ADDR_CTRL_STAT);              // control address
  wire                 match_hit = (count_ff == match_ff);
  wire [2:0]           byte_idx  = cfg_addr[2:0];                             // byte within group
  wire                 pre_tick;                                              // pre-scaled edge
  wire                 pre_level;                                             // pre-scaled level
  wire [7:0]           status;                                                // status byte

  // pre-scaler cleared outside counting or when counter is cleared
  rtcc_prescale u_pre (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clear   (~run | cnt_clr),
    .step    (cnt_rise),
    .tick    (pre_tick),
    .level   (pre_level)
  );

  // byte merge for counter and match writes
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BYTES; gb++) begin : g_byte
      assign cnt_wr_val[gb*8 +: 8] = (cfg_wr & cnt_sel[gb]) ? cfg_wdata : count_ff[gb*8 +: 8];
      assign mat_wr_val[gb*8 +: 8] = (cfg_wr & mat_sel[gb]) ? cfg_wdata : match_ff[gb*8 +: 8];
    end
  endgenerate

  // control written at its address, untouched by block reset
  assign nxt_ctrl = (cfg_wr & ctrl_hit) ? cfg_wdata : ctrl_ff;

  // release counts config clock edges once causes are gone
  assign nxt_blk_rst = hold_src ? 1'b1 : ((blk_rst_ff & cfg_rise & (rel_ff == REL_LAST)) ? 1'b0 : blk_rst_ff);
  assign nxt_rel     = hold_src ? 2'h0 : ((blk_rst_ff & cfg_rise) ? 2'(rel_ff + 2'h1) : rel_ff);

  // counter: reset, clear, host write, then pre-scaled step
  assign nxt_count = hold ? '0 :
                     cnt_clr ? '0 :
                     cnt_wr ? cnt_wr_val :
                     (pre_tick & run & match_hit & ctrl_ff[BIT_CLR_MATCH]) ? '0 :
                     (pre_tick & run) ? CNT_W'(count_ff + 40'h1) :
                     count_ff;
  assign nxt_match = hold ? '0 : mat_wr_val;

  // match output gated by enable
  assign nxt_match_out = ~hold & ctrl_ff[BIT_MATCH_EN] & match_hit;

  // status reflects live block state
  assign status = {
    hold,                                            // in reset
    run,                                             // counting
    match_out_ff,                                    // match output
    ctrl_ff[BIT_XT_HI:BIT_XT_LO],                    // mode driven
    pre_level,                                       // pre-scaled clock
    (count_ff != '0),                                // counter nonzero
    ctrl_ff[BIT_OSC_SEL]                             // ownership driven
  };

  // read selection
  assign nxt_rdata = ctrl_hit ? status :
                     (|cnt_sel) ? 8'(count_ff >> {byte_idx, 3'h0}) :
                     (|mat_sel) ? 8'(match_ff >> {byte_idx, 3'h0}) :
                     8'h00;

  // control register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // reset release state and edge samples
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      blk_rst_ff     <= 1'b1;
      rel_ff         <= 2'h0;
      cfg_clk_prv_ff <= 1'b0;
      cnt_clk_prv_ff <= 1'b0;
    end else begin
      blk_rst_ff     <= nxt_blk_rst;
      rel_ff         <= nxt_rel;
      cfg_clk_prv_ff <= config_port_clock;
      cnt_clk_prv_ff <= counter_clock;
    end
  end

  // counter, match value, match output
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_ff     <= '0;
      match_ff     <= '0;
      match_out_ff <= 1'b0;
    end else begin
      count_ff     <= nxt_count;
      match_ff     <= nxt_match;
      match_out_ff <= nxt_match_out;
    end
  end

  // read data path
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= cfg_rd ? nxt_rdata : rdata_ff;
      rvalid_ff <= cfg_rd;
    end
  end

  // outputs straight from flops
  assign cfg_rdata                = rdata_ff;
  assign cfg_rvalid               = rvalid_ff;
  assign match_output             = match_out_ff;
  assign crystal_mode_output      = ctrl_ff[BIT_XT_HI:BIT_XT_LO];
  assign oscillator_select_output = ctrl_ff[BIT_OSC_SEL];

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_hold_clears;
    hold_src |=> (count_ff == '0) && (match_ff == '0) && !match_output;
  endproperty
  a_hold_clears: assert property (p_hold_clears) else $error("counter block not cleared in reset");

  property p_release;
    !hold_src && blk_rst_ff && cfg_rise |=> (blk_rst_ff == ($past(rel_ff) != REL_LAST));
  endproperty
  a_release: assert property (p_release) else $error("reset release on wrong edge");

  property p_no_step_in_reset;
    hold |-> !pre_tick;
  endproperty
  a_no_step_in_reset: assert property (p_no_step_in_reset) else $error("step while in reset");

  property p_step;
    pre_tick && !cnt_wr && !cnt_clr && !(match_hit && ctrl_ff[BIT_CLR_MATCH]) |=> count_ff == CNT_W'($past(count_ff) + 40'h1);
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  property p_keep_disabled;
    !ctrl_ff[BIT_CNT_EN] && !hold && !cnt_clr && !cnt_wr |=> $stable(count_ff);
  endproperty
  a_keep_disabled: assert property (p_keep_disabled) else $error("counter moved while disabled");

  property p_match_out;
    !hold ##0 (ctrl_ff[BIT_MATCH_EN] && match_hit) |=> match_output;
  endproperty
  a_match_out: assert property (p_match_out) else $error("match output missing");

  property p_match_gate;
    !ctrl_ff[BIT_MATCH_EN] |=> !match_output;
  endproperty
  a_match_gate: assert property (p_match_gate) else $error("match output not gated");

  property p_clr_on_match;
    pre_tick && match_hit && ctrl_ff[BIT_CLR_MATCH] && !cnt_wr |=> count_ff == '0;
  endproperty
  a_clr_on_match: assert property (p_clr_on_match) else $error("no clear on match");

  property p_cnt_clear;
    cnt_clr |=> (count_ff == '0) ##1 (!$past(cnt_clr) || (count_ff == '0));
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not held at zero");

  property p_status_read;
    cfg_rd && ctrl_hit |=> cfg_rvalid && (cfg_rdata == $past(status));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_count_read;
    cfg_rd && cnt_sel[0] |=> cfg_rvalid && (cfg_rdata == $past(count_ff[7:0]));
  endproperty
  a_count_read: assert property (p_count_read) else $error("counter byte read wrong");
endmodule : rtcc_core
`default_nettype wire

// ===== sim/rtcc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the config byte port
module rtcc_host (
  input  wire logic       clk_sys,   // system clock
  output logic      [7:0] cfg_addr,  // byte address
  output logic      [7:0] cfg_wdata, // write byte
  output logic            cfg_wr,    // write strobe
  output logic            cfg_rd,    // read strobe
  input  wire logic [7:0] cfg_rdata, // read byte
  input  wire logic       cfg_rvalid // read byte valid
);
  // idle bus from time zero
  initial begin
    {cfg_addr, cfg_wdata, cfg_wr, cfg_rd} = '0;
  end
  // address and data travel in one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge clk_sys);
    cfg_wr    <= 1'b0;
    cfg_wdata <= ~d; // released data stops showing the last byte
  endtask : wr
  // read with a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n = 0;
    @(posedge clk_sys);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge clk_sys);
    cfg_rd   <= 1'b0;
    #1;
    while (cfg_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    ok = (cfg_rvalid === 1'b1);
    d  = cfg_rdata;
  endtask : rd
endmodule : rtcc_host
`default_nettype wire

// ===== sim/rtcc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
// bench for the counter control block with a reference model
module rtcc_core_test;
  import rtcc_pkg::*;
  logic        clk_sys = 1'b0;           // system clock
  logic        reset   = 1'b1;           // sync reset
  logic        cpc     = 1'b0;           // config port clock
  logic        cclk    = 1'b0;           // counter clock
  logic        io_up   = 1'b1;           // io supply good
  logic [7:0]  addr, wdata, rdata, b;    // bus and scratch
  logic [7:0]  ctrl;                     // model control copy
  logic        wr, rd, rvalid, match;    // strobes, match out
  logic        osc;                      // ownership out
  logic [1:0]  xt;                       // crystal mode out
  logic [39:0] m_cnt, m_mat, v;          // model counter, match
  int          m_pre;                    // model pre-scaler
  logic        m_blk;                    // model block reset
  bit          ok;                       // read answered
  int          errors      = 0;
  int          check_count = 0;
  initial forever #50 clk_sys = ~clk_sys;
  rtcc_host host (.clk_sys(clk_sys), .cfg_addr(addr), .cfg_wdata(wdata), .cfg_wr(wr),
                  .cfg_rd(rd), .cfg_rdata(rdata), .cfg_rvalid(rvalid));
  rtcc_core DUT (.clk_sys(clk_sys), .reset(reset), .config_port_clock(cpc), .counter_clock(cclk),
                 .io_supply_up(io_up), .cfg_addr(addr), .cfg_wdata(wdata), .cfg_wr(wr), .cfg_rd(rd),
                 .cfg_rdata(rdata), .cfg_rvalid(rvalid), .match_output(match),
                 .crystal_mode_output(xt), .oscillator_select_output(osc));
  // compare and count
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic summarize;
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // model holds from reset and control
  function automatic void fix;
    if (m_blk) m_mat = '0;
    if (m_blk || !ctrl[1]) m_cnt = '0;
    if (m_blk || !ctrl[6] || !ctrl[1]) m_pre = 0;
  endfunction : fix
  // write plus model update
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a == ADDR_CTRL_STAT) ctrl = d;
    if (a == ADDR_CTRL_STAT && d[7]) m_blk = 1'b1;
    if (a >= ADDR_COUNT_BASE && a < ADDR_COUNT_BASE + 8'h05) m_cnt[8*(a-ADDR_COUNT_BASE) +: 8] = d;
    if (a >= ADDR_MATCH_BASE && a < ADDR_MATCH_BASE + 8'h05) m_mat[8*(a-ADDR_MATCH_BASE) +: 8] = d;
    fix();
  endtask : w
  // read, a missing answer ends the run
  task automatic r(input logic [7:0] a, output logic [7:0] d);
    host.rd(a, d, ok);
    if (!ok) begin
      errors++;
      summarize();
    end
  endtask : r
  // five bytes, lsb first
  task automatic rdv(input logic [7:0] base, output logic [39:0] x);
    for (int i = 0; i < NUM_BYTES; i++) begin
      r(base + 8'(i), b);
      x[8*i +: 8] = b;
    end
  endtask : rdv
  task automatic ld(input logic [7:0] base, input logic [39:0] x);
    for (int i = 0; i < NUM_BYTES; i++) w(base + 8'(i), x[8*i +: 8]);
  endtask : ld
  // counter, match value and match output against the model
  task automatic cc;
    rdv(ADDR_COUNT_BASE, v);
    chk(v, m_cnt);
    rdv(ADDR_MATCH_BASE, v);
    chk(v, m_mat);
    chk(match, m_cnt == m_mat && ctrl[5] && !m_blk);
  endtask : cc
  // status byte against the model
  task automatic st;
    r(ADDR_CTRL_STAT, b);
    chk(b[7], m_blk);
    chk(b[6], ctrl[6] & ~m_blk);
    chk(b[5:0], {(m_cnt == m_mat && ctrl[5] && !m_blk), ctrl[4:3], m_pre[6], (m_cnt != 40'h0), ctrl[0]});
  endtask : st
  // n counter clock edges, two system cycles each
  task automatic ce(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      cclk <= 1'b1;
      @(posedge clk_sys);
      cclk <= 1'b0;
      if (!m_blk && ctrl[6] && ctrl[1]) m_pre++;
      if (m_pre == 64) begin
        m_pre = -64;
        m_cnt = (ctrl[2] && m_cnt == m_mat) ? 40'h0 : m_cnt + 40'h1;
      end
    end
    repeat (3) @(posedge clk_sys);
  endtask : ce
  task automatic pulse;
    @(posedge clk_sys);
    cpc <= 1'b1;
    @(posedge clk_sys);
    cpc <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse
  // release needs two config clock edges
  task automatic rel;
    pulse();
    st();
    pulse();
    m_blk = 1'b0;
    st();
  endtask : rel
  // main sequence
  initial begin
    void'($urandom(77));
    ctrl  = 8'h00;
    m_cnt = '0;
    m_mat = '0;
    m_pre = 0;
    m_blk = 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({match, xt, osc}, 4'h0);
    rel();
    for (int i = 0; i < 8; i++) begin
      w(ADDR_CTRL_STAT, {3'h0, i[2:1], 2'h0, i[0]});
      repeat (2) @(posedge clk_sys);
      #1;
      chk({xt, osc}, i[2:0]);
    end
    w(ADDR_CTRL_STAT, 8'h2a);
    ld(ADDR_COUNT_BASE, 40'({$urandom, $urandom}));
    ld(ADDR_MATCH_BASE, m_cnt + 40'h1);
    cc();
    r(8'h45, b);
    chk(b, 8'h00);
    w(ADDR_CTRL_STAT, 8'h6a);
    ce(63);
    cc();
    ce(1);
    cc();
    ce(128);
    cc();
    w(ADDR_CTRL_STAT, 8'h2a);
    ce(100);
    cc();
    w(ADDR_CTRL_STAT, 8'h6a);
    ce(63);
    cc();
    ce(1);
    cc();
    w(ADDR_CTRL_STAT, 8'h4a);
    ld(ADDR_MATCH_BASE, m_cnt + 40'h1);
    ce(128);
    cc();
    w(ADDR_CTRL_STAT, 8'h6a);
    ld(ADDR_MATCH_BASE, (m_cnt + 40'h1) ^ 40'h80_0000_0000);
    ce(128);
    cc();
    w(ADDR_CTRL_STAT, 8'h6e);
    ld(ADDR_MATCH_BASE, m_cnt);
    cc();
    ce(128);
    cc();
    w(ADDR_CTRL_STAT, 8'h28);
    ld(ADDR_COUNT_BASE, 40'h5);
    cc();
    w(ADDR_CTRL_STAT, 8'hea);
    st();
    cc();
    chk(xt, 2'h1);
    w(ADDR_CTRL_STAT, 8'h6a);
    st();
    ce(64);
    cc();
    rel();
    cc();
    ce(64);
    cc();
    @(posedge clk_sys);
    io_up <= 1'b0;
    @(posedge clk_sys);
    m_blk = 1'b1;
    fix();
    st();
    cc();
    @(posedge clk_sys);
    io_up <= 1'b1;
    rel();
    summarize();
  end
endmodule : rtcc_core_test
`default_nettype wire
